// ### src/core_regs_pkg.sv
/*
 * shared constants and carrier types for the core control register bank.
 * assumes a 6-bit i/o address space and an 8-bit execution unit outside.
 */
package core_regs_pkg;

    // ----------------------------------------
    // i/o offsets
    // ----------------------------------------
    localparam logic [5:0] OFF_CORE_CTRL = 6'h05;
    localparam logic [5:0] OFF_PAGE_SEL  = 6'h3B;
    localparam logic [5:0] OFF_CLK_DIV   = 6'h3C;
    localparam logic [5:0] OFF_SP_LOW    = 6'h3D;
    localparam logic [5:0] OFF_SP_HIGH   = 6'h3E;
    localparam logic [5:0] OFF_FLAGS     = 6'h3F;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int FLAG_GIE     = 7;
    localparam int FLAG_BITCOPY = 6;
    localparam int FLAG_HALF    = 5;
    localparam int FLAG_SIGN    = 4;
    localparam int FLAG_OVF     = 3;
    localparam int FLAG_NEG     = 2;
    localparam int FLAG_ZERO    = 1;
    localparam int FLAG_CARRY   = 0;
    localparam int CTRL_EXT_MEM = 7;
    localparam int CTRL_WAIT    = 6;
    localparam int CTRL_SLEEP   = 5;
    localparam int CTRL_MODE_HI = 4;
    localparam int CTRL_MODE_LO = 3;
    localparam int DIV_ENABLE   = 7;
    localparam int PAGE_UPPER   = 0;

    // ----------------------------------------
    // reset values and masks
    // ----------------------------------------
    localparam logic [7:0]  FLAGS_RST     = 8'h00;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [7:0]  CTRL_WR_MASK  = 8'hF8;
    localparam logic [15:0] SP_RST        = 16'h0000;
    localparam logic        PAGE_RST      = 1'b0;
    localparam logic [6:0]  DIV_FIELD_RST = 7'h00;

    // ----------------------------------------
    // timing and vector constants
    // ----------------------------------------
    localparam logic [7:0] DIV_BASE        = 8'h81;
    localparam logic [2:0] EXT_CYCLES_BASE = 3'h3;
    localparam int         VEC_COUNT       = 24;
    localparam int         IRQ_COUNT       = VEC_COUNT - 1;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_IDLE, MODE_RESERVED, MODE_POWER_DOWN, MODE_POWER_SAVE
    } sleep_mode_t;

    typedef enum logic [2:0] {
        SP_HOLD, SP_PUSH1, SP_PUSH2, SP_POP1, SP_POP2
    } stack_op_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] value;
    } flag_upd_t;

endpackage

// ### src/core_status_stack_sleep_control.sv
/*
 * core flags, stack pointer, page select, core control, clock divider
 * and interrupt vectoring of an 8-bit processor core.
 * assumes the execution unit drives the i/o port and the strobes below
 * synchronously to REF_CLK, and keeps push/pop away from i/o sp writes.
 */

// Contract
// R1 - flags bit 7 is global interrupt enable; zero blocks every interrupt
// R2 - taking an interrupt clears global enable; return-from-irq sets it
// R3 - flags bit 6 is source and destination of bit copy instructions
// R4 - sign bit 4 always equals negative xor overflow
// R5 - half 5, overflow 3, negative 2, zero 1, carry 0 from results
// R6 - software saves and restores flags around an interrupt handler
// R7 - flags register sits at i/o location 3F
// R8 - 16-bit stack pointer, high at 3E, low at 3D, reset zero
// R9 - push byte decrements by one, call or interrupt by two
// R10 - pop byte increments by one, return or irq return by two
// R11 - software loads stack pointer above 60 before calls or interrupts
// R12 - page bit 0 selects lower or upper program half for extended load
// R13 - ordinary program load ignores the page select register
// R14 - control bit 7 enables external memory and port overrides
// R15 - control bit 6 adds one wait cycle to three-cycle access
// R16 - sleep instruction sleeps only while control bit 5 is set
// R17 - software sets sleep enable just before the sleep instruction
// R18 - control bits 2 to 0 read as zero
// R19 - divider enabled: tick at reference rate over 129 minus field
// R20 - field latched only when enabling from disabled; discarded on clear
// R21 - sleep mode bits: idle, reserved, power-down, power-save
// R22 - 24 vectors two words apart from 0000 to 002E
// R23 - lowest pending vector number wins arbitration
// R24 - serviced interrupt flag is cleared when vectoring
module core_status_stack_sleep_control #(
    parameter int IRQ_N = core_regs_pkg::IRQ_COUNT
) (
    // clock and reset
    input  wire logic                        REF_CLK,
    input  wire logic                        RESET_N,
    // i/o register port
    input  wire core_regs_pkg::io_req_t      IO_REQ,
    output logic [7:0]                       IO_RDATA,
    // execution unit strobes
    input  wire core_regs_pkg::flag_upd_t    FLAG_UPD,
    input  wire logic                        BIT_STORE_EN,
    input  wire logic                        BIT_STORE_VAL,
    input  wire core_regs_pkg::stack_op_t    STACK_OP,
    input  wire logic                        RETURN_FROM_IRQ,
    input  wire logic                        SLEEP_INSTR,
    input  wire logic                        PROG_LOAD,
    input  wire logic                        PROG_LOAD_EXT,
    input  wire logic [15:0]                 PROG_Z,
    // interrupt sources
    input  wire logic [IRQ_N-1:0]            IRQ_PENDING,
    input  wire logic                        IRQ_READY,
    // core state
    output logic [7:0]                       FLAGS,
    output logic                             BIT_COPY,
    output logic [15:0]                      STACK_POINTER,
    output logic                             IRQ_TAKE,
    output logic [15:0]                      IRQ_VECTOR,
    output logic [IRQ_N-1:0]                 IRQ_CLEAR,
    output logic [16:0]                      PROG_ADDR,
    // external memory and power
    output logic                             EXT_MEM_EN,
    output logic                             PORTA_ADDR_DATA,
    output logic                             PORTC_ADDR_HIGH,
    output logic [2:0]                       EXT_ACCESS_CYCLES,
    output logic                             SLEEP_REQ,
    output core_regs_pkg::sleep_mode_t       SLEEP_MODE,
    output logic                             CLK_TICK
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // lowest set bit wins, matching vector order
    function automatic logic [4:0] lowest(input logic [IRQ_N-1:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = IRQ_N - 1; i >= 0; i--)
            if (v[i])
                idx = 5'(i);
        return idx;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0]  flags;
    logic [7:0]  ctrl;
    logic [15:0] sp;
    logic        upper_page_bit;
    logic        divider_enable;
    logic [6:0]  divide_factor_field;
    logic [7:0]  tick_cnt;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire wr_flags = IO_REQ.wr && IO_REQ.addr == core_regs_pkg::OFF_FLAGS;
    wire wr_ctrl  = IO_REQ.wr && IO_REQ.addr == core_regs_pkg::OFF_CORE_CTRL;
    wire wr_sp_lo = IO_REQ.wr && IO_REQ.addr == core_regs_pkg::OFF_SP_LOW;
    wire wr_sp_hi = IO_REQ.wr && IO_REQ.addr == core_regs_pkg::OFF_SP_HIGH;
    wire wr_page  = IO_REQ.wr && IO_REQ.addr == core_regs_pkg::OFF_PAGE_SEL;
    wire wr_div   = IO_REQ.wr && IO_REQ.addr == core_regs_pkg::OFF_CLK_DIV;
    wire sp_write = wr_sp_lo || wr_sp_hi;

    // ----------------------------------------
    // interrupt arbitration
    // ----------------------------------------
    // nothing is taken while global enable is low
    wire        take = flags[core_regs_pkg::FLAG_GIE] && IRQ_READY
                       && |IRQ_PENDING;                                // R1
    wire [4:0]  win  = lowest(IRQ_PENDING);                            // R23
    wire [15:0] next_vector = {10'h000, 5'(win + 5'h01), 1'b0};        // R22

    // ----------------------------------------
    // flags next value
    // ----------------------------------------
    wire [7:0] alu_flags = (flags & ~FLAG_UPD.mask)
                         | (FLAG_UPD.value & FLAG_UPD.mask);           // R5
    wire [7:0] io_flags  = wr_flags ? IO_REQ.wdata : alu_flags;        // R7
    wire       next_copy = (BIT_STORE_EN && !wr_flags) ? BIT_STORE_VAL
                         : io_flags[core_regs_pkg::FLAG_BITCOPY];      // R3
    // taking wins over a simultaneous return
    wire       next_gie  = take ? 1'b0
                         : RETURN_FROM_IRQ ? 1'b1
                         : io_flags[core_regs_pkg::FLAG_GIE];          // R2
    // sign is rebuilt every update, so a raw write cannot break it
    wire       next_sign = io_flags[core_regs_pkg::FLAG_NEG]
                         ^ io_flags[core_regs_pkg::FLAG_OVF];          // R4
    wire [7:0] next_flags = {next_gie, next_copy,
                             io_flags[core_regs_pkg::FLAG_HALF],
                             next_sign, io_flags[3:0]};

    // ----------------------------------------
    // stack pointer next value
    // ----------------------------------------
    // an i/o write takes priority, then the interrupt push
    wire [15:0] sp_delta_dn2 = sp - 16'h0002;
    wire [15:0] sp_io = {wr_sp_hi ? IO_REQ.wdata : sp[15:8],
                         wr_sp_lo ? IO_REQ.wdata : sp[7:0]};           // R8
    logic [15:0] next_sp;
    always_comb
    begin
        if (sp_write)
            next_sp = sp_io;
        else if (take)
            next_sp = sp_delta_dn2;                                    // R9
        else
            unique case (STACK_OP)
                core_regs_pkg::SP_HOLD:  next_sp = sp;
                core_regs_pkg::SP_PUSH1: next_sp = sp - 16'h0001;      // R9
                core_regs_pkg::SP_PUSH2: next_sp = sp_delta_dn2;       // R9
                core_regs_pkg::SP_POP1:  next_sp = sp + 16'h0001;      // R10
                core_regs_pkg::SP_POP2:  next_sp = sp + 16'h0002;      // R10
                default:                 next_sp = sp;
            endcase
    end

    // ----------------------------------------
    // divider next values
    // ----------------------------------------
    // factor is frozen while running to avoid a glitchy period change
    wire       div_set   = wr_div && IO_REQ.wdata[core_regs_pkg::DIV_ENABLE];
    wire       div_latch = div_set && !divider_enable;                 // R20
    wire       div_clear = wr_div && !IO_REQ.wdata[core_regs_pkg::DIV_ENABLE];
    wire [7:0] divisor   = core_regs_pkg::DIV_BASE
                         - {1'b0, divide_factor_field};                // R19
    wire       tick_hit  = tick_cnt == divisor - 8'h01;
    wire       next_tick = !divider_enable || tick_hit;                // R19

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = 8'h00;
        if (IO_REQ.rd)
            unique case (IO_REQ.addr)
                core_regs_pkg::OFF_FLAGS:     next_rdata = flags;
                core_regs_pkg::OFF_SP_HIGH:   next_rdata = sp[15:8];
                core_regs_pkg::OFF_SP_LOW:    next_rdata = sp[7:0];
                core_regs_pkg::OFF_CORE_CTRL: next_rdata =
                    ctrl & core_regs_pkg::CTRL_WR_MASK;                // R18
                core_regs_pkg::OFF_PAGE_SEL:  next_rdata =
                    {7'h00, upper_page_bit};
                core_regs_pkg::OFF_CLK_DIV:   next_rdata =
                    {divider_enable, divide_factor_field};
                default:                      next_rdata = 8'h00;
            endcase
    end

    // ----------------------------------------
    // registers of the core
    // ----------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!RESET_N)
        begin
            flags          <= core_regs_pkg::FLAGS_RST;
            sp             <= core_regs_pkg::SP_RST;
            ctrl           <= core_regs_pkg::CTRL_RST;
            upper_page_bit <= core_regs_pkg::PAGE_RST;
        end
        else
        begin
            flags <= next_flags;
            sp    <= next_sp;
            if (wr_ctrl)
                ctrl <= IO_REQ.wdata & core_regs_pkg::CTRL_WR_MASK;    // R18
            if (wr_page)
                upper_page_bit <= IO_REQ.wdata[core_regs_pkg::PAGE_UPPER];
        end
    end

    // divider state and tick output
    always_ff @(posedge REF_CLK)
    begin
        if (!RESET_N)
        begin
            divider_enable      <= 1'b0;
            divide_factor_field <= core_regs_pkg::DIV_FIELD_RST;
            tick_cnt            <= 8'h00;
            CLK_TICK            <= 1'b0;
        end
        else
        begin
            if (div_latch)
            begin
                divider_enable      <= 1'b1;
                divide_factor_field <= IO_REQ.wdata[6:0];              // R20
            end
            else if (div_clear)
                divider_enable <= 1'b0;                                // R20
            tick_cnt <= (div_latch || tick_hit || !divider_enable)
                      ? 8'h00 : tick_cnt + 8'h01;
            CLK_TICK <= next_tick && !div_latch;
        end
    end

    // outward registered state
    always_ff @(posedge REF_CLK)
    begin
        if (!RESET_N)
        begin
            IO_RDATA          <= 8'h00;
            IRQ_TAKE          <= 1'b0;
            IRQ_VECTOR        <= 16'h0000;
            IRQ_CLEAR         <= '0;
            PROG_ADDR         <= 17'h0_0000;
            SLEEP_REQ         <= 1'b0;
            SLEEP_MODE        <= core_regs_pkg::MODE_IDLE;
            EXT_ACCESS_CYCLES <= core_regs_pkg::EXT_CYCLES_BASE;
        end
        else
        begin
            IO_RDATA   <= next_rdata;
            IRQ_TAKE   <= take;
            IRQ_VECTOR <= take ? next_vector : IRQ_VECTOR;
            IRQ_CLEAR  <= take ? IRQ_N'(1) << win : '0;                // R24
            if (PROG_LOAD)
                PROG_ADDR <= {PROG_LOAD_EXT && upper_page_bit,
                              PROG_Z};                                 // R12 R13
            SLEEP_REQ  <= SLEEP_INSTR
                       && ctrl[core_regs_pkg::CTRL_SLEEP];             // R16
            SLEEP_MODE <= core_regs_pkg::sleep_mode_t'(
                {ctrl[core_regs_pkg::CTRL_MODE_HI],
                 ctrl[core_regs_pkg::CTRL_MODE_LO]});                  // R21
            EXT_ACCESS_CYCLES <= core_regs_pkg::EXT_CYCLES_BASE
                + {2'b00, ctrl[core_regs_pkg::CTRL_WAIT]};             // R15
        end
    end

    // ----------------------------------------
    // direct state views
    // ----------------------------------------
    // external bus takes both ports regardless of direction settings
    assign FLAGS             = flags;
    assign BIT_COPY          = flags[core_regs_pkg::FLAG_BITCOPY];
    assign STACK_POINTER     = sp;
    assign EXT_MEM_EN        = ctrl[core_regs_pkg::CTRL_EXT_MEM];      // R14
    assign PORTA_ADDR_DATA   = ctrl[core_regs_pkg::CTRL_EXT_MEM];      // R14
    assign PORTC_ADDR_HIGH   = ctrl[core_regs_pkg::CTRL_EXT_MEM];      // R14

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_take_now;
        take && !sp_write;
    endsequence

    a_gie_blocks_irq: assert property (
        !flags[core_regs_pkg::FLAG_GIE] |=> !IRQ_TAKE) // R1
        else $error("interrupt taken with global enable low");
    a_take_clears_gie: assert property (
        s_take_now |=> !FLAGS[7] && IRQ_TAKE
        && STACK_POINTER == $past(sp) - 16'h0002) // R2
        else $error("interrupt entry did not clear enable or push two");
    a_return_from_irq_sets_gie: assert property (
        RETURN_FROM_IRQ && !take |=> FLAGS[7]) // R2
        else $error("return from irq did not set enable");
    a_sign_is_xor: assert property (
        FLAGS[4] == (FLAGS[2] ^ FLAGS[3])) // R4
        else $error("sign flag differs from negative xor overflow");
    a_bit_store_t: assert property (
        BIT_STORE_EN && !wr_flags |=> BIT_COPY == $past(BIT_STORE_VAL)) // R3
        else $error("bit store value not held in flag six");
    a_push_one_step: assert property (
        STACK_OP == core_regs_pkg::SP_PUSH1 && !take && !sp_write
        |=> STACK_POINTER == $past(sp) - 16'h0001) // R9
        else $error("byte push did not decrement by one");
    a_pop_two_step: assert property (
        STACK_OP == core_regs_pkg::SP_POP2 && !take && !sp_write
        |=> STACK_POINTER == $past(sp) + 16'h0002) // R10
        else $error("address pop did not increment by two");
    a_page_select_use: assert property (
        PROG_LOAD |=> PROG_ADDR[16] == ($past(PROG_LOAD_EXT)
        && $past(upper_page_bit))) // R12
        else $error("program page bit misapplied");
    a_ctrl_reserved_zero: assert property (
        IO_REQ.rd |=> IO_RDATA[2:0] == 3'h0
        || $past(IO_REQ.addr) != core_regs_pkg::OFF_CORE_CTRL) // R18
        else $error("reserved control bits read non-zero");
    a_sleep_gated: assert property (
        SLEEP_INSTR && !ctrl[core_regs_pkg::CTRL_SLEEP] |=> !SLEEP_REQ) // R16
        else $error("sleep requested without sleep enable");
    a_div_rejects_field: assert property (
        wr_div && divider_enable |=> $stable(divide_factor_field)) // R20
        else $error("divide field changed while divider ran");
    a_irq_lowest_wins: assert property (
        take |=> IRQ_CLEAR == IRQ_N'(1) << lowest($past(IRQ_PENDING))
        && IRQ_VECTOR[0] == 1'b0) // R23
        else $error("wrong interrupt chosen or cleared");

endmodule

// ### tb/testbench.sv
/*
 * self-checking bench for the core flags, stack, control, divider and
 * interrupt block. assumes the design's assertions sit in its own files
 * and that its ports follow the hand-over contract cycle for cycle.
 */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // clock, reset and design hookup
    // ----------------------------------------
    logic                           REF_CLK = 1'b0;
    logic                           RESET_N = 1'b0;
    core_regs_pkg::io_req_t         IO_REQ = '0;
    core_regs_pkg::flag_upd_t       FLAG_UPD = '0;
    core_regs_pkg::stack_op_t       STACK_OP = core_regs_pkg::SP_HOLD;
    logic                           BIT_STORE_EN = 1'b0;
    logic                           BIT_STORE_VAL = 1'b0;
    logic                           RETURN_FROM_IRQ = 1'b0;
    logic                           SLEEP_INSTR = 1'b0;
    logic                           PROG_LOAD = 1'b0;
    logic                           PROG_LOAD_EXT = 1'b0;
    logic [15:0]                    PROG_Z = 16'h0000;
    logic [22:0]                    IRQ_PENDING = '0;
    logic                           IRQ_READY = 1'b1;
    logic [7:0]                     IO_RDATA, FLAGS;
    logic [15:0]                    STACK_POINTER, IRQ_VECTOR;
    logic [22:0]                    IRQ_CLEAR;
    logic [16:0]                    PROG_ADDR;
    logic [2:0]                     EXT_ACCESS_CYCLES;
    logic                           BIT_COPY, IRQ_TAKE, EXT_MEM_EN;
    logic                           PORTA_ADDR_DATA, PORTC_ADDR_HIGH;
    logic                           SLEEP_REQ, CLK_TICK;
    core_regs_pkg::sleep_mode_t     SLEEP_MODE;
    int                             error_cnt = 0;
    int                             cmp_count = 0;
    int                             cyc = 0;
    int                             take_cnt = 0;

    always #2 REF_CLK = ~REF_CLK;

    core_status_stack_sleep_control u_dut (
        .REF_CLK           (REF_CLK),
        .RESET_N           (RESET_N),
        .IO_REQ            (IO_REQ),
        .IO_RDATA          (IO_RDATA),
        .FLAG_UPD          (FLAG_UPD),
        .BIT_STORE_EN      (BIT_STORE_EN),
        .BIT_STORE_VAL     (BIT_STORE_VAL),
        .STACK_OP          (STACK_OP),
        .RETURN_FROM_IRQ   (RETURN_FROM_IRQ),
        .SLEEP_INSTR       (SLEEP_INSTR),
        .PROG_LOAD         (PROG_LOAD),
        .PROG_LOAD_EXT     (PROG_LOAD_EXT),
        .PROG_Z            (PROG_Z),
        .IRQ_PENDING       (IRQ_PENDING),
        .IRQ_READY         (IRQ_READY),
        .FLAGS             (FLAGS),
        .BIT_COPY          (BIT_COPY),
        .STACK_POINTER     (STACK_POINTER),
        .IRQ_TAKE          (IRQ_TAKE),
        .IRQ_VECTOR        (IRQ_VECTOR),
        .IRQ_CLEAR         (IRQ_CLEAR),
        .PROG_ADDR         (PROG_ADDR),
        .EXT_MEM_EN        (EXT_MEM_EN),
        .PORTA_ADDR_DATA   (PORTA_ADDR_DATA),
        .PORTC_ADDR_HIGH   (PORTC_ADDR_HIGH),
        .EXT_ACCESS_CYCLES (EXT_ACCESS_CYCLES),
        .SLEEP_REQ         (SLEEP_REQ),
        .SLEEP_MODE        (SLEEP_MODE),
        .CLK_TICK          (CLK_TICK)
    );

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge REF_CLK)
    begin
        cyc++;
        if (IRQ_TAKE === 1'b1)
            take_cnt++;
        if (cyc == 5000)
        begin
            error_cnt++;
            final_report();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic final_report();
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // write strobe for one cycle; effect is visible after return
    task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge REF_CLK) IO_REQ <= '{1'b1, 1'b0, a, d};
        @(posedge REF_CLK) IO_REQ <= '0;
        #1;
    endtask

    task automatic io_chk(input logic [5:0] a, input logic [7:0] exp);
        @(posedge REF_CLK) IO_REQ <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge REF_CLK) IO_REQ <= '0;
        #1 chk(IO_RDATA, exp);
    endtask

    task automatic stack_step(input core_regs_pkg::stack_op_t op,
                              input logic [15:0] exp);
        @(posedge REF_CLK) STACK_OP <= op;
        @(posedge REF_CLK) STACK_OP <= core_regs_pkg::SP_HOLD;
        #1 chk(STACK_POINTER, exp);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_and_flags();
        io_chk(6'h3D, 8'h00);
        io_chk(6'h3E, 8'h00);
        io_chk(6'h05, 8'h00);
        // sign cannot be written: neg and ovf both set gives sign clear
        io_wr(6'h3F, 8'h7F);
        chk(FLAGS, 8'h6F);
        io_chk(6'h3F, 8'h6F);
        @(posedge REF_CLK) FLAG_UPD <= '{8'h2F, 8'h04};
        @(posedge REF_CLK) FLAG_UPD <= '0;
        #1 chk(FLAGS, 8'h54);
        @(posedge REF_CLK)
        begin
            BIT_STORE_EN <= 1'b1;
            BIT_STORE_VAL <= 1'b0;
        end
        @(posedge REF_CLK) BIT_STORE_EN <= 1'b0;
        #1 chk({BIT_COPY, FLAGS}, 9'h014);
    endtask

    task automatic t_stack();
        io_wr(6'h3D, 8'h01);
        io_wr(6'h3E, 8'h12);
        chk(STACK_POINTER, 16'h1201);
        stack_step(core_regs_pkg::SP_PUSH1, 16'h1200);
        stack_step(core_regs_pkg::SP_PUSH2, 16'h11FE);
        stack_step(core_regs_pkg::SP_POP1, 16'h11FF);
        stack_step(core_regs_pkg::SP_POP2, 16'h1201);
        io_chk(6'h3E, 8'h12);
    endtask

    task automatic t_control();
        for (int m = 0; m < 4; m++)
        begin
            io_wr(6'h05, 8'(m << 3));
            // mode output is registered from the control byte
            @(posedge REF_CLK) #1 chk(SLEEP_MODE, m);
        end
        chk({EXT_MEM_EN, PORTA_ADDR_DATA, PORTC_ADDR_HIGH}, 0);
        chk(EXT_ACCESS_CYCLES, 3);
        io_wr(6'h05, 8'hC7);
        chk({EXT_MEM_EN, PORTA_ADDR_DATA, PORTC_ADDR_HIGH}, 7);
        io_chk(6'h05, 8'hC0);
        chk(EXT_ACCESS_CYCLES, 4);
        @(posedge REF_CLK) SLEEP_INSTR <= 1'b1;
        @(posedge REF_CLK) SLEEP_INSTR <= 1'b0;
        #1 chk(SLEEP_REQ, 0);
        io_wr(6'h05, 8'h20);
        @(posedge REF_CLK) SLEEP_INSTR <= 1'b1;
        @(posedge REF_CLK) SLEEP_INSTR <= 1'b0;
        #1 chk(SLEEP_REQ, 1);
    endtask

    task automatic t_page();
        io_wr(6'h3B, 8'h01);
        for (int e = 0; e < 2; e++)
        begin
            @(posedge REF_CLK)
            begin
                PROG_LOAD <= 1'b1;
                PROG_LOAD_EXT <= e[0];
                PROG_Z <= 16'hF00D;
            end
            @(posedge REF_CLK) PROG_LOAD <= 1'b0;
            #1 chk(PROG_ADDR, {e[0], 16'hF00D});
        end
    endtask

    task automatic count_ticks(input int n, input int exp);
        int k;
        k = 0;
        repeat (n) @(posedge REF_CLK) #1 k += int'(CLK_TICK === 1'b1);
        chk(k, exp);
    endtask

    task automatic t_divider();
        io_wr(6'h3C, 8'hFE);
        repeat (4) @(posedge REF_CLK);
        count_ticks(30, 10);
        // field may not change while running
        io_wr(6'h3C, 8'h81);
        io_chk(6'h3C, 8'hFE);
        io_wr(6'h3C, 8'h05);
        io_chk(6'h3C, 8'h7E);
        count_ticks(6, 6);
    endtask

    task automatic t_interrupt();
        int base;
        io_wr(6'h3F, 8'h00);
        io_wr(6'h3E, 8'h01);
        io_wr(6'h3D, 8'h00);
        base = take_cnt;
        @(posedge REF_CLK) IRQ_PENDING <= 23'h000024;
        repeat (5) @(posedge REF_CLK);
        #1 chk(take_cnt - base, 0);
        io_wr(6'h3F, 8'h80);
        @(posedge REF_CLK) #1;
        chk({IRQ_TAKE, IRQ_VECTOR}, 17'h10006);
        chk(IRQ_CLEAR, 23'h000004);
        chk({FLAGS[7], STACK_POINTER}, 17'h000FE);
        @(posedge REF_CLK) IRQ_PENDING <= 23'h400000;
        #1 chk(IRQ_TAKE, 0);
        // handler saves the flags and puts them back before returning
        io_chk(6'h3F, 8'h00);
        io_wr(6'h3F, 8'h00);
        @(posedge REF_CLK) RETURN_FROM_IRQ <= 1'b1;
        @(posedge REF_CLK) RETURN_FROM_IRQ <= 1'b0;
        #1 chk(FLAGS[7], 1);
        @(posedge REF_CLK) #1;
        chk({IRQ_TAKE, IRQ_VECTOR}, 17'h1002E);
        chk(IRQ_CLEAR, 23'h400000);
        @(posedge REF_CLK) IRQ_PENDING <= '0;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        @(posedge REF_CLK);
        t_reset_and_flags();
        t_stack();
        t_control();
        t_page();
        t_divider();
        t_interrupt();
        final_report();
    end
endmodule
